/* File: hdl/serial_frame_cfg.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_frame_cfg (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        coreClk,
  input  wire logic        regWrEn,
  input  wire logic [1:0]  regSel,
  input  wire logic [31:0] regWrData,
  output logic [31:0]      regRdData,
  input  wire logic        cpuHalted,
  input  wire logic        sleepActive,
  input  wire logic [3:0]  padIn,
  input  wire logic        txBit,
  input  wire logic        sckDrive,
  input  wire logic        ssDrive,
  output logic [3:0]       padOut,
  output logic [3:0]       padOe,
  output logic [3:0]       rxPadClaim,
  output logic             voteBit,
  output logic             voteValid,
  output logic             parityEn,
  output logic             breakDetectEn,
  output logic             smartCardEn,
  output logic             syncMode,
  output logic             wakeReq,
  output logic             coreHalted
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] padAt(input logic [1:0] b,
                                       input logic [1:0] o);
    return b + o;
  endfunction

  function automatic logic [3:0] firstSample(input logic [1:0] sa,
                                             input logic       e8);
    if (e8)
      return serial_cfg_pkg::SAMP8_BASE + {2'b00, sa};
    return serial_cfg_pkg::SAMP16_BASE + {1'b0, sa, 1'b0};
  endfunction

  function automatic logic majority(input logic a,
                                    input logic b,
                                    input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  // ----------------------------------------------------------------
  // bus domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] serial_control_a;
    logic [31:0] serial_control_b;
    logic [31:0] dbg;
    logic [31:0] rdData;
    logic        haltReq;
    logic        sleepReq;
  } bus_s;

  bus_s busQ;
  bus_s busD;
  logic       syncBusy;
  logic [2:0] coreSynced;
  logic       wrA;
  logic       wrB;
  logic       sendEn;

  assign wrA = regWrEn && regSel == serial_cfg_pkg::SEL_CTRL_A && !syncBusy;
  assign wrB = regWrEn && regSel == serial_cfg_pkg::SEL_CTRL_B && !syncBusy;
  assign sendEn = wrA || wrB;

  always_comb
  begin
    busD = busQ;
    if (wrA)
    begin
      if (!busQ.serial_control_a[serial_cfg_pkg::ENABLE_BIT])
        busD.serial_control_a = regWrData & serial_cfg_pkg::CTRL_A_MASK;
      else
        busD.serial_control_a[serial_cfg_pkg::ENABLE_BIT] =
          regWrData[serial_cfg_pkg::ENABLE_BIT];
    end
    if (wrB)
      busD.serial_control_b = regWrData & serial_cfg_pkg::CTRL_B_MASK;
    if (regWrEn && regSel == serial_cfg_pkg::SEL_DBG)
      busD.dbg = regWrData & serial_cfg_pkg::DBG_MASK;
    case (regSel)
      serial_cfg_pkg::SEL_CTRL_A: busD.rdData = busQ.serial_control_a;
      serial_cfg_pkg::SEL_CTRL_B: busD.rdData = busQ.serial_control_b;
      serial_cfg_pkg::SEL_DBG:    busD.rdData = busQ.dbg;
      serial_cfg_pkg::SEL_SYNC:   busD.rdData = {31'h0, syncBusy};
      default:                    busD.rdData = 32'h0000_0000;
    endcase
    busD.haltReq  = cpuHalted && busQ.dbg[serial_cfg_pkg::HALT_BIT];
    busD.sleepReq = sleepActive;
    if (sys_rst)
    begin
      busD = '0;
      busD.serial_control_a = serial_cfg_pkg::CTRL_A_RESET;
      busD.serial_control_b = serial_cfg_pkg::CTRL_B_RESET;
      busD.dbg   = serial_cfg_pkg::DBG_RESET;
    end
  end

  always_ff @(posedge clk)
  begin
    busQ <= busD;
  end

  assign regRdData = busQ.rdData;

  // ----------------------------------------------------------------
  // synchronized enable bits: {hw select, rx enable, enable}
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                 rstMeta;
    logic                 rstSync;
    serial_cfg_pkg::cfg_s cfgMeta;
    serial_cfg_pkg::cfg_s cfgSync;
    logic                 haltMeta;
    logic                 haltSync;
    logic                 sleepMeta;
    logic                 sleepSync;
    logic [3:0]           padMeta;
    logic [3:0]           padSync;
    logic                 rxPrev;
    logic [3:0]           sampCnt;
    logic [1:0]           samples;
    logic                 voteBit;
    logic                 voteValid;
    logic [3:0]           padOut;
    logic [3:0]           padOe;
    logic [3:0]           rxClaim;
    logic                 parityEn;
    logic                 breakEn;
    logic                 smartEn;
    logic                 syncMode;
    logic                 wakeReq;
    logic                 halted;
  } core_s;

  core_s coreQ;
  core_s coreD;

  cfg_sync_bridge u_cfg_sync_bridge (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .coreClk  (coreClk),
    .coreRst  (coreQ.rstSync),
    .sendEn   (sendEn),
    .sendData ({busD.serial_control_b[serial_cfg_pkg::HWSEL_BIT],
                busD.serial_control_b[serial_cfg_pkg::RXEN_BIT],
                busD.serial_control_a[serial_cfg_pkg::ENABLE_BIT]}),
    .busy     (syncBusy),
    .coreData (coreSynced)
  );

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  serial_cfg_pkg::cfg_s busCfg;
  serial_cfg_pkg::cfg_s cfg;
  logic       enOn;
  logic       rxOn;
  logic       hwSel;
  logic       isSpi;
  logic       isMaster;
  logic       is8x;
  logic       rxBit;
  logic [3:0] firstPos;
  logic [3:0] topCnt;

  assign busCfg.cmode = busQ.serial_control_a[serial_cfg_pkg::CMODE_BIT];
  assign busCfg.frame_format_sel  = busQ.serial_control_a[serial_cfg_pkg::FRAME_FORMAT_SEL_LSB +: 4];
  assign busCfg.adj    = busQ.serial_control_a[serial_cfg_pkg::ADJ_LSB +: 2];
  assign busCfg.rate   = busQ.serial_control_a[serial_cfg_pkg::RATE_LSB +: 3];
  assign busCfg.rxPad  = busQ.serial_control_a[serial_cfg_pkg::RXPAD_LSB +: 2];
  assign busCfg.outPad = busQ.serial_control_a[serial_cfg_pkg::OUTPAD_LSB +: 2];
  assign busCfg.mode  = busQ.serial_control_a[serial_cfg_pkg::MODE_LSB +: 3];

  // quasi-static fields: changed only while disabled, so a plain
  // two-flop pass is safe and needs no handshake
  assign cfg      = coreQ.cfgSync;
  assign enOn     = coreSynced[0];
  assign rxOn     = coreSynced[0] && coreSynced[1];
  assign hwSel    = coreSynced[2];
  assign isMaster = cfg.mode == serial_cfg_pkg::MODE_SPI_MASTER;
  assign isSpi    = isMaster || cfg.mode == serial_cfg_pkg::MODE_SPI_SLAVE;
  assign is8x     = cfg.rate == serial_cfg_pkg::RATE_8X_A ||
                    cfg.rate == serial_cfg_pkg::RATE_8X_B;
  assign rxBit    = coreQ.padSync[cfg.rxPad];
  assign firstPos = firstSample(cfg.adj, is8x);
  assign topCnt   = is8x ? serial_cfg_pkg::OS8_TOP : serial_cfg_pkg::OS16_TOP;

  always_comb
  begin
    coreD = coreQ;
    coreD.rstMeta   = sys_rst;
    coreD.rstSync   = coreQ.rstMeta;
    coreD.cfgMeta   = busCfg;
    coreD.cfgSync   = coreQ.cfgMeta;
    coreD.haltMeta  = busQ.haltReq;
    coreD.haltSync  = coreQ.haltMeta;
    coreD.sleepMeta = busQ.sleepReq;
    coreD.sleepSync = coreQ.sleepMeta;
    coreD.padMeta   = padIn;
    coreD.padSync   = coreQ.padMeta;
    coreD.halted    = coreQ.haltSync;
    coreD.syncMode  = cfg.cmode;
    // reserved codes fall through to a plain frame
    coreD.parityEn  = cfg.frame_format_sel == serial_cfg_pkg::FRAME_FORMAT_SEL_PARITY ||
                      cfg.frame_format_sel == serial_cfg_pkg::FRAME_FORMAT_SEL_BREAK_PAR;
    coreD.breakEn   = cfg.frame_format_sel == serial_cfg_pkg::FRAME_FORMAT_SEL_BREAK ||
                      cfg.frame_format_sel == serial_cfg_pkg::FRAME_FORMAT_SEL_BREAK_PAR;
    coreD.smartEn   = cfg.frame_format_sel == serial_cfg_pkg::FRAME_FORMAT_SEL_ISO7816;
    coreD.voteValid = 1'b0;
    coreD.rxPrev    = rxBit;
    coreD.rxClaim   = rxOn ? 4'h1 << cfg.rxPad : 4'h0;
    // sleep never gates the link logic; a start edge asks for wake
    coreD.wakeReq   = coreQ.sleepSync && rxOn && coreQ.rxPrev &&
                      !rxBit;
    coreD.padOe  = 4'h0;
    coreD.padOut = 4'h0;
    if (enOn)
    begin
      coreD.padOe[cfg.outPad]  = 1'b1;
      coreD.padOut[cfg.outPad] = txBit;
      if (isSpi && isMaster)
      begin
        coreD.padOe[padAt(cfg.outPad, 2'h1)]  = 1'b1;
        coreD.padOut[padAt(cfg.outPad, 2'h1)] = sckDrive;
        if (hwSel)
        begin
          coreD.padOe[padAt(cfg.outPad, 2'h2)]  = 1'b1;
          coreD.padOut[padAt(cfg.outPad, 2'h2)] = ssDrive;
        end
      end
    end
    // a halted link freezes the sample clock, keeping vote state
    if (rxOn && !isSpi && !coreQ.halted)
    begin
      coreD.sampCnt = coreQ.sampCnt == topCnt ? 4'h0 : coreQ.sampCnt + 4'h1;
      if (coreQ.sampCnt == firstPos)
        coreD.samples[0] = rxBit;
      if (coreQ.sampCnt == firstPos + 4'h1)
        coreD.samples[1] = rxBit;
      if (coreQ.sampCnt == firstPos + 4'h2)
      begin
        coreD.voteBit   = majority(coreQ.samples[0], coreQ.samples[1], rxBit);
        coreD.voteValid = 1'b1;
      end
    end
    else if (!rxOn)
      coreD.sampCnt = 4'h0;
    if (coreQ.rstSync)
    begin
      coreD = '0;
      coreD.rstMeta = sys_rst;
      coreD.rstSync = coreQ.rstMeta;
    end
  end

  always_ff @(posedge coreClk)
  begin
    coreQ <= coreD;
  end

  assign padOut        = coreQ.padOut;
  assign padOe         = coreQ.padOe;
  assign rxPadClaim    = coreQ.rxClaim;
  assign voteBit       = coreQ.voteBit;
  assign voteValid     = coreQ.voteValid;
  assign parityEn      = coreQ.parityEn;
  assign breakDetectEn = coreQ.breakEn;
  assign smartCardEn   = coreQ.smartEn;
  assign syncMode      = coreQ.syncMode;
  assign wakeReq       = coreQ.wakeReq;
  assign coreHalted    = coreQ.halted;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_cmode_follow;
    @(posedge coreClk) disable iff (coreQ.rstSync)
      coreQ.cfgMeta.cmode ##1 coreQ.cfgMeta.cmode |=> syncMode;
  endproperty
  a_cmode_follow: assert property (p_cmode_follow)
    else $error("clocked mode bit not followed");

  property p_frame_format_sel_parity;
    @(posedge coreClk) disable iff (coreQ.rstSync)
      cfg.frame_format_sel == serial_cfg_pkg::FRAME_FORMAT_SEL_BREAK_PAR |=> parityEn && breakDetectEn;
  endproperty
  a_frame_format_sel_parity: assert property (p_frame_format_sel_parity)
    else $error("break with parity decode wrong");

  property p_frame_format_sel_reserved;
    @(posedge coreClk) disable iff (coreQ.rstSync)
      cfg.frame_format_sel inside {4'h2, 4'h3, 4'h6} |=>
        !parityEn && !breakDetectEn && !smartCardEn;
  endproperty
  a_frame_format_sel_reserved: assert property (p_frame_format_sel_reserved)
    else $error("reserved frame code enabled a feature");

  property p_samp16;
    @(posedge coreClk) disable iff (coreQ.rstSync)
      voteValid && !is8x && $stable(cfg) |->
        $past(coreQ.sampCnt) == 4'h8 + {1'b0, cfg.adj, 1'b0};
  endproperty
  a_samp16: assert property (p_samp16)
    else $error("16x vote taken at wrong sample");

  property p_samp8;
    @(posedge coreClk) disable iff (coreQ.rstSync)
      voteValid && is8x && $stable(cfg) |->
        $past(coreQ.sampCnt) == 4'h4 + {2'b00, cfg.adj};
  endproperty
  a_samp8: assert property (p_samp8)
    else $error("8x vote taken at wrong sample");

  property p_rx_pad;
    @(posedge coreClk) disable iff (coreQ.rstSync)
      rxOn && $stable(cfg.rxPad) |=> rxPadClaim == 4'h1 << $past(cfg.rxPad);
  endproperty
  a_rx_pad: assert property (p_rx_pad)
    else $error("receive pad not claimed");

  property p_master_pins;
    @(posedge coreClk) disable iff (coreQ.rstSync)
      enOn && isMaster && !hwSel |=> $countones(padOe) == 2;
  endproperty
  a_master_pins: assert property (p_master_pins)
    else $error("master without hw select drives wrong pins");

  property p_slave_one_out;
    @(posedge coreClk) disable iff (coreQ.rstSync)
      enOn && cfg.mode == serial_cfg_pkg::MODE_SPI_SLAVE |=> $onehot(padOe);
  endproperty
  a_slave_one_out: assert property (p_slave_one_out)
    else $error("slave drives more than its data out");

  property p_rx_release;
    @(posedge coreClk) disable iff (coreQ.rstSync)
      !rxOn |=> rxPadClaim == 4'h0;
  endproperty
  a_rx_release: assert property (p_rx_release)
    else $error("disabled receiver still claims pad");

  property p_halt_freeze;
    @(posedge coreClk) disable iff (coreQ.rstSync)
      coreQ.halted && rxOn |=> $stable(coreQ.sampCnt) && !voteValid;
  endproperty
  a_halt_freeze: assert property (p_halt_freeze)
    else $error("sampling ran while halted");

  property p_sync_busy;
    @(posedge clk) disable iff (sys_rst)
      wrA |=> syncBusy ##[1:20] !syncBusy;
  endproperty
  a_sync_busy: assert property (p_sync_busy)
    else $error("handshake did not run");

  property p_protect;
    @(posedge clk) disable iff (sys_rst)
      wrA && busQ.serial_control_a[serial_cfg_pkg::ENABLE_BIT] |=>
        $stable(busQ.serial_control_a[serial_cfg_pkg::FRAME_FORMAT_SEL_LSB +: 4]);
  endproperty
  a_protect: assert property (p_protect)
    else $error("format changed while enabled");

endmodule
`default_nettype wire

/* File: include/serial_cfg_pkg.sv */
// Functional notes
// - mode bit picks async or clocked, unhandshaked
// - frame format field selects frame type
// - 16x oversampling vote positions from sample adjust
// - 8x oversampling vote positions from sample adjust
// - receive pad field routes receive input
// - SPI master/slave drive pin directions themselves
// - hardware select output only with enable bit
// - disabled receiver releases the data input pad
// - in and out pad fields place SPI signals
// - synchronized bits cross domains by handshake
// - keeps running in sleep, can request wake
// - debug halt only when halt control set
`default_nettype none
package serial_cfg_pkg;

  // ----------------------------------------------------------------
  // register selects
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_CTRL_A = 2'h0;
  localparam logic [1:0] SEL_CTRL_B = 2'h1;
  localparam logic [1:0] SEL_DBG    = 2'h2;
  localparam logic [1:0] SEL_SYNC   = 2'h3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT = 1;
  localparam int MODE_LSB   = 2;
  localparam int RATE_LSB   = 13;
  localparam int OUTPAD_LSB = 16;
  localparam int RXPAD_LSB  = 20;
  localparam int ADJ_LSB    = 22;
  localparam int FRAME_FORMAT_SEL_LSB   = 24;
  localparam int CMODE_BIT  = 28;
  localparam int HWSEL_BIT  = 13;
  localparam int RXEN_BIT   = 17;
  localparam int HALT_BIT   = 0;

  // ----------------------------------------------------------------
  // writable masks and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_A_MASK  = 32'h1FF3_E01E;
  localparam logic [31:0] CTRL_B_MASK  = 32'h0002_2000;
  localparam logic [31:0] DBG_MASK     = 32'h0000_0001;
  localparam logic [31:0] CTRL_A_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_B_RESET = 32'h0000_0000;
  localparam logic [31:0] DBG_RESET    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] FRAME_FORMAT_SEL_PLAIN     = 4'h0;
  localparam logic [3:0] FRAME_FORMAT_SEL_PARITY    = 4'h1;
  localparam logic [3:0] FRAME_FORMAT_SEL_BREAK     = 4'h4;
  localparam logic [3:0] FRAME_FORMAT_SEL_BREAK_PAR = 4'h5;
  localparam logic [3:0] FRAME_FORMAT_SEL_ISO7816   = 4'h7;
  localparam logic [2:0] MODE_SPI_SLAVE  = 3'h2;
  localparam logic [2:0] MODE_SPI_MASTER = 3'h3;
  localparam logic [2:0] RATE_8X_A = 3'h2;
  localparam logic [2:0] RATE_8X_B = 3'h3;

  // ----------------------------------------------------------------
  // oversampling counts
  // ----------------------------------------------------------------
  // vote positions count from one, the counter from zero, so the
  // last 8x position still fits inside a 0..7 count
  localparam logic [3:0] SAMP16_BASE = 4'h6;
  localparam logic [3:0] SAMP8_BASE  = 4'h2;
  localparam logic [3:0] OS16_TOP    = 4'hF;
  localparam logic [3:0] OS8_TOP     = 4'h7;

  typedef struct packed {
    logic       cmode;
    logic [3:0] frame_format_sel;
    logic [1:0] adj;
    logic [2:0] rate;
    logic [1:0] rxPad;
    logic [1:0] outPad;
    logic [2:0] mode;
  } cfg_s;

endpackage
`default_nettype wire

/* File: hdl/cfg_sync_bridge.sv */
`timescale 1ns/1ps
`default_nettype none
module cfg_sync_bridge (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       coreClk,
  input  wire logic       coreRst,
  input  wire logic       sendEn,
  input  wire logic [2:0] sendData,
  output logic            busy,
  output logic [2:0]      coreData
);

  // ----------------------------------------------------------------
  // toggle handshake; data held still while a toggle is in flight
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       reqTgl;
    logic [2:0] data;
    logic       ackMeta;
    logic       ackSync;
  } src_s;

  typedef struct packed {
    logic       reqMeta;
    logic       reqSync;
    logic       ackTgl;
    logic [2:0] data;
  } dst_s;

  src_s srcQ;
  src_s srcD;
  dst_s dstQ;
  dst_s dstD;

  assign busy     = srcQ.reqTgl != srcQ.ackSync;
  assign coreData = dstQ.data;

  always_comb
  begin
    srcD = srcQ;
    srcD.ackMeta = dstQ.ackTgl;
    srcD.ackSync = srcQ.ackMeta;
    if (sendEn && !busy)
    begin
      srcD.reqTgl = ~srcQ.reqTgl;
      srcD.data   = sendData;
    end
    if (sys_rst)
    begin
      srcD = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    srcQ <= srcD;
  end

  always_comb
  begin
    dstD = dstQ;
    dstD.reqMeta = srcQ.reqTgl;
    dstD.reqSync = dstQ.reqMeta;
    if (dstQ.reqSync != dstQ.ackTgl)
    begin
      dstD.data   = srcQ.data;
      dstD.ackTgl = dstQ.reqSync;
    end
    if (coreRst)
    begin
      dstD = '0;
    end
  end

  always_ff @(posedge coreClk)
  begin
    dstQ <= dstD;
  end

endmodule
`default_nettype wire

/* File: sim/serial_line_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_line_partner (
  input  wire logic       coreClk,
  input  wire logic [3:0] padOut,
  input  wire logic [3:0] padOe,
  input  wire logic [1:0] lineIdx,
  input  wire logic       lineLevel,
  output logic      [3:0] padIn
);
  // ----------------------------------------------------------------
  // pad resolution
  // ----------------------------------------------------------------
  logic churnQ;
  initial churnQ = 1'b0;
  // pads nobody drives wander, so a stale level never passes for data
  always @(posedge coreClk) churnQ <= ~churnQ;
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (padOe[i] === 1'b1)
        padIn[i] = padOut[i];
      else if (i == int'(lineIdx))
        padIn[i] = lineLevel;
      else
        padIn[i] = churnQ ^ i[0];
    end
  end
endmodule
`default_nettype wire

/* File: sim/serial_frame_cfg_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_frame_cfg_bench;
  logic clk = 1'b0, coreClk = 1'b0, sysRst = 1'b1, regWrEn = 1'b0;
  logic [1:0] regSel = 2'h0, lineIdx = 2'h1;
  logic [31:0] regWrData = 32'h0000_0000, regRdData, seed = 32'hbfbc_4cf3;
  logic cpuHalted = 1'b0, sleepActive = 1'b0, lineLevel = 1'b1;
  logic txBit = 1'b0, sckDrive = 1'b0, ssDrive = 1'b0;
  logic [3:0] padIn, padOut, padOe, rxPadClaim;
  logic voteBit, voteValid, parityEn, breakDetectEn, smartCardEn;
  logic syncMode, wakeReq, coreHalted;
  int failures = 0, checks = 0, cycles = 0, wakeCnt = 0, vCnt = 0, n0;
  logic [3:0] fl [5] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h7};
  logic [31:0] d, rv;
  localparam logic [31:0] RXEN = 32'h0002_0000;
  always #5 clk = ~clk;
  always #6 coreClk = ~coreClk;
  always @(posedge coreClk) if (wakeReq === 1'b1) wakeCnt++;
  always @(posedge coreClk) if (voteValid === 1'b1) vCnt++;
  serial_frame_cfg u_serial_frame_cfg (.clk(clk), .sys_rst(sysRst),
    .coreClk(coreClk), .regWrEn(regWrEn), .regSel(regSel),
    .regWrData(regWrData), .regRdData(regRdData), .cpuHalted(cpuHalted),
    .sleepActive(sleepActive), .padIn(padIn), .txBit(txBit),
    .sckDrive(sckDrive), .ssDrive(ssDrive), .padOut(padOut), .padOe(padOe),
    .rxPadClaim(rxPadClaim), .voteBit(voteBit), .voteValid(voteValid),
    .parityEn(parityEn), .breakDetectEn(breakDetectEn),
    .smartCardEn(smartCardEn), .syncMode(syncMode), .wakeReq(wakeReq),
    .coreHalted(coreHalted));
  serial_line_partner u_serial_line_partner (.coreClk(coreClk),
    .padOut(padOut), .padOe(padOe), .lineIdx(lineIdx),
    .lineLevel(lineLevel), .padIn(padIn));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] cfgA(logic en, logic [2:0] m,
    logic [2:0] sr, logic [1:0] dp, logic [1:0] rp, logic [1:0] sa,
    logic [3:0] f, logic cm);
    return {3'h0, cm, f, sa, rp, 2'h0, dp, sr, 8'h00, m, en, 1'b0};
  endfunction
  function automatic logic [3:0] oeExp(logic [2:0] m, logic [1:0] dp,
    logic ss);
    logic [3:0] o;
    o = 4'h0;
    o[dp] = 1'b1;
    if (m == serial_cfg_pkg::MODE_SPI_MASTER)
    begin
      o[dp + 2'h1] = 1'b1;
      o[dp + 2'h2] = ss;
    end
    return o;
  endfunction
  function automatic logic [2:0] formExp(logic [3:0] f);
    case (f)
      4'h1: return 3'h4;
      4'h4: return 3'h2;
      4'h5: return 3'h6;
      4'h7: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // a busy check is only asked for on writes known to start a handshake
  task automatic wr(logic [1:0] s, logic [31:0] v, logic cb = 1'b0);
    int n;
    @(negedge clk);
    regWrEn = 1'b1;
    regSel = s;
    regWrData = v;
    @(negedge clk);
    regWrEn = 1'b0;
    regSel = serial_cfg_pkg::SEL_SYNC;
    @(negedge clk);
    if (cb) chk("busy", 32'h1, {31'h0, regRdData[0]});
    n = 0;
    while (regRdData[0] !== 1'b0 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    repeat (8) @(posedge coreClk);
    @(negedge clk);
  endtask
  task automatic rd(logic [1:0] s, output logic [31:0] v);
    @(negedge clk);
    regSel = s;
    @(negedge clk);
    v = regRdData;
  endtask
  // measures one whole vote window, skipping the one in progress
  task automatic votePeriod(int expN, logic lvl);
    int n;
    n = 0;
    while (voteValid !== 1'b1 && n < 64)
    begin
      @(negedge coreClk);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge coreClk);
      n++;
    end while (voteValid !== 1'b1 && n < 64);
    chk("votePeriod", expN, n);
    chk("voteBit", lvl, voteBit);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    // 5 cycles so the core side also sees four reset edges
    repeat (5) @(negedge clk);
    sysRst = 1'b0;
    for (int s = 0; s < 3; s++)
    begin
      rd(s[1:0], rv);
      chk("resetVal", 32'h0, rv);
    end
    wr(serial_cfg_pkg::SEL_CTRL_B, RXEN, 1'b1);
    foreach (fl[i])
    begin
      wr(serial_cfg_pkg::SEL_CTRL_A, cfgA(0, 0, 0, 0, 1, 0, fl[i], i[0]));
      chk("frame_format_sel", formExp(fl[i]), {parityEn, breakDetectEn, smartCardEn});
      chk("syncMode", i[0], syncMode);
    end
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      d = seed & ~32'h0000_0002;
      d[27:24] = fl[seed[2:0] % 5];
      wr(serial_cfg_pkg::SEL_CTRL_A, d);
      rd(serial_cfg_pkg::SEL_CTRL_A, rv);
      chk("serial_control_a", d & serial_cfg_pkg::CTRL_A_MASK, rv);
      wr(serial_cfg_pkg::SEL_CTRL_B, seed);
      rd(serial_cfg_pkg::SEL_CTRL_B, rv);
      chk("serial_control_b", seed & serial_cfg_pkg::CTRL_B_MASK, rv);
    end
    d = cfgA(1, 0, 0, 3, 1, 0, 4'h1, 0);
    wr(serial_cfg_pkg::SEL_CTRL_A, 32'h0);
    wr(serial_cfg_pkg::SEL_CTRL_A, d);
    wr(serial_cfg_pkg::SEL_CTRL_A, cfgA(1, 0, 2, 0, 2, 3, 4'h7, 1));
    rd(serial_cfg_pkg::SEL_CTRL_A, rv);
    chk("locked", d, rv);
    wr(serial_cfg_pkg::SEL_CTRL_A, cfgA(0, 0, 2, 0, 2, 3, 4'h7, 1));
    rd(serial_cfg_pkg::SEL_CTRL_A, rv);
    chk("unlock", d & ~32'h0000_0002, rv);
    for (int r = 0; r < 4; r++)
    begin
      wr(serial_cfg_pkg::SEL_CTRL_A, 32'h0);
      wr(serial_cfg_pkg::SEL_CTRL_B, RXEN);
      d = cfgA(1, 0, 0, r[1:0] + 2'h2, r[1:0], 0, 4'h0, 0);
      wr(serial_cfg_pkg::SEL_CTRL_A, d);
      chk("rxClaim", 4'h1 << r, rxPadClaim);
      chk("uartOe", oeExp(0, r[1:0] + 2'h2, 0), padOe);
      wr(serial_cfg_pkg::SEL_CTRL_B, 32'h0);
      chk("rxOff", 4'h0, rxPadClaim);
      chk("rxPadOe", 1'b0, padOe[r]);
    end
    lineIdx = 2'h1;
    wr(serial_cfg_pkg::SEL_CTRL_B, RXEN);
    wr(serial_cfg_pkg::SEL_CTRL_A, 32'h0);
    wr(serial_cfg_pkg::SEL_CTRL_A, cfgA(1, 0, 0, 3, 1, 2, 4'h0, 0));
    votePeriod(16, 1'b1);
    lineLevel = 1'b0;
    votePeriod(16, 1'b0);
    wr(serial_cfg_pkg::SEL_CTRL_A, 32'h0);
    wr(serial_cfg_pkg::SEL_CTRL_A, cfgA(1, 0, 2, 3, 1, 3, 4'h0, 0));
    votePeriod(8, 1'b0);
    lineLevel = 1'b1;
    votePeriod(8, 1'b1);
    cpuHalted = 1'b1;
    wr(serial_cfg_pkg::SEL_DBG, 32'h0);
    chk("noHalt", 1'b0, coreHalted);
    wr(serial_cfg_pkg::SEL_DBG, 32'h1);
    chk("halt", 1'b1, coreHalted);
    n0 = vCnt;
    repeat (40) @(posedge coreClk);
    chk("frozen", n0, vCnt);
    cpuHalted = 1'b0;
    n0 = wakeCnt;
    lineLevel = 1'b0;
    repeat (10) @(posedge coreClk);
    chk("awakeNoReq", n0, wakeCnt);
    lineLevel = 1'b1;
    sleepActive = 1'b1;
    repeat (10) @(posedge coreClk);
    lineLevel = 1'b0;
    repeat (10) @(posedge coreClk);
    chk("wake", n0 + 1, wakeCnt);
    sleepActive = 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      d = cfgA(1, k < 2 ? 3'h3 : 3'h2, 0, 1, 0, 0, 4'h0, 0);
      wr(serial_cfg_pkg::SEL_CTRL_A, 32'h0);
      wr(serial_cfg_pkg::SEL_CTRL_B, RXEN | (k == 0 ? 32'h2000 : 32'h0));
      wr(serial_cfg_pkg::SEL_CTRL_A, d);
      seed = lfsr(seed);
      @(negedge clk);
      {txBit, sckDrive, ssDrive} = seed[2:0];
      repeat (6) @(posedge coreClk);
      @(negedge clk);
      chk("spiOe", oeExp(d[4:2], 1, k == 0), padOe);
      chk("dataOut", txBit, padOut[1]);
      if (k < 2) chk("sckOut", sckDrive, padOut[2]);
      if (k == 0) chk("ssOut", ssDrive, padOut[3]);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
